// file: dv/bmsl_boot_properties.sv
module bmsl_boot_chk (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        irq_high_voltage,
  input wire logic        first_capture_input_pin,
  input wire logic        boot_enable_select_pin,
  input wire logic        loader_or_jump_select_pin,
  input wire logic        security_bit,
  input wire logic [7:0]  first_parallel_port_pins,
  input wire logic [7:0]  second_parallel_port_pins,
  input wire logic [7:0]  third_parallel_port_pins,
  input wire logic [3:0]  mode_q,
  input wire logic        run_q,
  input wire logic [15:0] exec_addr_q,
  input wire logic        ports_to_user_q,
  input wire logic [7:0]  nv_erased_value_q
);
  wire logic pins_ok = irq_high_voltage && first_capture_input_pin && boot_enable_select_pin;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence rel_s;
    $past(reset) && !reset;
  endsequence
  loader_entry_a: assert property (rel_s |=> (mode_q == 4'h2) ==
    $past(pins_ok && !loader_or_jump_select_pin && security_bit)) else $error("bad loader entry");
  jump_entry_a: assert property (rel_s |=> (mode_q == 4'h4) ==
    $past(pins_ok && loader_or_jump_select_pin)) else $error("bad jump entry");
  mode_hold_a: assert property (mode_q != 4'h8 |=> $stable(mode_q))
    else $error("mode changed");
  single_run_a: assert property (rel_s ##1 mode_q == 4'h1 |->
    ##[25:35] (run_q && ports_to_user_q)) else $error("single chip not running");
  jump_addr_a: assert property ($rose(run_q) && mode_q == 4'h4 |->
    exec_addr_q == $past({second_parallel_port_pins, third_parallel_port_pins})
    && $past(first_parallel_port_pins) == 8'hCC) else $error("bad jump target");
  loader_addr_a: assert property (run_q && mode_q == 4'h2 |-> exec_addr_q == 16'h0051)
    else $error("bad loader target");
  erased_value_a: assert property (mode_q != 4'h8 |-> nv_erased_value_q == 8'hFF)
    else $error("bad erased value");
  run_hold_a: assert property (run_q |=> run_q && $stable(exec_addr_q))
    else $error("run dropped");
endmodule : bmsl_boot_chk
bind bmsl_boot bmsl_boot_chk u_chk (.*);

// file: dv/bmsl_host.sv
module bmsl_host #(
  parameter int BIT = 16
)
(
  input  wire logic ref_clk,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge ref_clk);
      rxd = f[i];
      repeat (BIT - 1) @(negedge ref_clk);
    end
  endtask : send
endmodule : bmsl_host

// file: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bmsl_pkg::*;
  logic ref_clk, reset, irq_high_voltage, first_capture_input_pin, security_bit, rxd;
  logic boot_enable_select_pin, loader_or_jump_select_pin, run_q, loader_waiting_q;
  logic ports_to_user_q;
  logic [7:0] first_parallel_port_pins, second_parallel_port_pins, third_parallel_port_pins;
  logic [7:0] ram_rd_addr, ram_rd_data, nv_erased_value_q, b1, b2;
  logic [3:0] mode_q, m;
  logic [15:0] exec_addr_q;
  logic [31:0] seed;
  int err_count, checks;
  bmsl_boot #(.BIT_CYC(16)) uut (.*);
  bmsl_host #(.BIT(16)) u_host (.ref_clk(ref_clk), .rxd(rxd));
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lf
  function automatic logic [3:0] exp_mode(input logic [4:0] p);
    if (&p[4:2] && p[1]) return 4'h4;
    if (&p[4:2] && p[0]) return 4'h2;
    return 4'h1;
  endfunction : exp_mode
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic boot(input logic [4:0] p);
    @(negedge ref_clk);
    {irq_high_voltage, first_capture_input_pin, boot_enable_select_pin,
      loader_or_jump_select_pin, security_bit} = p;
    reset = 1'b1;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    repeat (40) @(negedge ref_clk);
  endtask : boot
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    ram_rd_addr = a;
    repeat (2) @(negedge ref_clk);
    chk(ram_rd_data, e);
  endtask : rd
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    reset = 1'b1;
    seed = 32'h7091;
    ram_rd_addr = 8'h00;
    first_parallel_port_pins = 8'hCC;
    {second_parallel_port_pins, third_parallel_port_pins} = 16'h0000;
    boot(5'h00);
    for (int i = 0; i < 32; i++)
    begin
      seed = lf(seed);
      {second_parallel_port_pins, third_parallel_port_pins} = seed[15:0];
      boot(i[4:0]);
      m = exp_mode(i[4:0]);
      chk(mode_q, m);
      chk({run_q, ports_to_user_q}, {m != 4'h2, m == 4'h1});
      if (m == 4'h4) chk(exec_addr_q, seed[15:0]);
      loader_or_jump_select_pin = ~loader_or_jump_select_pin;
      repeat (3) @(negedge ref_clk);
      chk(mode_q, m);
    end
    $display("test mode_select done");
    chk(nv_erased_value_q, 8'hFF);
    first_parallel_port_pins = 8'h33;
    boot(5'h1E);
    chk(run_q, 1'b0);
    first_parallel_port_pins = 8'hCC;
    @(negedge ref_clk);
    {irq_high_voltage, first_capture_input_pin, boot_enable_select_pin,
      loader_or_jump_select_pin, security_bit} = 5'h1F;
    reset = 1'b1;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    repeat (10) @(negedge ref_clk);
    loader_or_jump_select_pin = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk({mode_q, run_q}, {4'h4, 1'b0});
    $display("test jump_refusals done");
    {b1, b2} = seed[23:8];
    boot(5'h1D);
    u_host.send(8'h03);
    u_host.send(b1);
    u_host.send(b2);
    repeat (20) @(negedge ref_clk);
    chk({run_q, exec_addr_q}, 17'h10051);
    rd(8'h50, 8'h03);
    rd(8'h51, b1);
    rd(8'h52, b2);
    $display("test loader_run done");
    seed = lf(seed);
    boot(5'h1D);
    u_host.send(8'h05);
    u_host.send(seed[7:0]);
    u_host.send(b2);
    repeat (20) @(negedge ref_clk);
    chk({run_q, loader_waiting_q}, 2'b01);
    {second_parallel_port_pins, third_parallel_port_pins} = 16'h0051;
    boot(5'h1E);
    chk(exec_addr_q, 16'h0051);
    rd(8'h50, 8'h05);
    rd(8'h51, seed[7:0]);
    $display("test loader_hold done");
    report_and_stop();
  end
endmodule : tb_top

// file: shared/bmsl_pkg.sv
// Contract
// - mode chosen at reset release from irq, capture and two select pins.
// - loader entered only when security bit reads 1 (inactive).
// - received bytes stored sequentially in ram from 0x0050 upward.
// - after count bytes received, execution starts at 0x0051.
// - serial framing 8N1 idle high, 9600 baud.
// - count larger than data sent keeps loader waiting, no execution.
// - reset while waiting leaves loaded ram contents intact.
// - jump address high byte from second port, low from third port.
// - erased nonvolatile data bytes read as 0xFF.
// - single-chip mode keeps all activity internal, ports to user.
package bmsl_pkg;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned BAUD           = 9600;
  localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD;
  localparam int unsigned HOLD_CYCLES    = 30;
  localparam logic [15:0] RAM_BASE       = 16'h0050;
  localparam logic [15:0] RAM_EXEC       = 16'h0051;
  localparam logic [7:0]  JUMP_KEY       = 8'hCC;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int unsigned RAM_DEPTH      = 176;

  typedef enum logic [3:0]
  {
    BMSL_SINGLE = 4'h1,
    BMSL_LOADER = 4'h2,
    BMSL_JUMP   = 4'h4,
    BMSL_HALT   = 4'h8
  } bmsl_mode_t;
endpackage : bmsl_pkg

// file: verilog/bmsl_boot.sv
module bmsl_boot
  import bmsl_pkg::*;
#(
  parameter int unsigned BIT_CYC = bmsl_pkg::BIT_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        irq_high_voltage,
  input  wire logic        first_capture_input_pin,
  input  wire logic        boot_enable_select_pin,
  input  wire logic        loader_or_jump_select_pin,
  input  wire logic        security_bit,
  input  wire logic [7:0]  first_parallel_port_pins,
  input  wire logic [7:0]  second_parallel_port_pins,
  input  wire logic [7:0]  third_parallel_port_pins,
  input  wire logic        rxd,
  input  wire logic [7:0]  ram_rd_addr,
  output logic [7:0]       ram_rd_data,
  output logic [3:0]       mode_q,
  output logic             run_q,
  output logic [15:0]      exec_addr_q,
  output logic             loader_waiting_q,
  output logic             ports_to_user_q,
  output logic [7:0]       nv_erased_value_q
);
  import bmsl_pkg::*;

  bmsl_mode_t  mode_r;
  logic        rst_d1_q;
  logic [4:0]  hold_q;
  logic        sel_ok_q;
  logic [7:0]  count_q;
  logic [7:0]  rcvd_q;
  logic        rx_v;
  logic [7:0]  rx_b;
  logic [7:0]  waddr;
  logic        we;

  bmsl_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx
  (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .rxd        (rxd),
    .byte_valid (rx_v),
    .byte_data  (rx_b)
  );

  assign we    = (mode_r == BMSL_LOADER) && rx_v && !run_q;
  assign waddr = 8'(RAM_BASE) + rcvd_q;

  bmsl_ram u_ram
  (
    .ref_clk (ref_clk),
    .we      (we),
    .waddr   (waddr),
    .wdata   (rx_b),
    .raddr   (ram_rd_addr),
    .rdata   (ram_rd_data)
  );

  always_ff @(posedge ref_clk)
    rst_d1_q <= reset;

  // mode sampled on first edge after reset release
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      mode_r <= BMSL_HALT;
    else if (rst_d1_q)
    begin
      if (irq_high_voltage && first_capture_input_pin && boot_enable_select_pin)
      begin
        if (loader_or_jump_select_pin)
          mode_r <= BMSL_JUMP;
        else if (security_bit)
          mode_r <= BMSL_LOADER;
        else
          mode_r <= BMSL_SINGLE;
      end
      else
        mode_r <= BMSL_SINGLE;
    end
  end

  assign mode_q = mode_r;

  // select pins must stay put for the hold window
  always_ff @(posedge ref_clk)
  begin
    if (reset || rst_d1_q)
    begin
      hold_q   <= '0;
      sel_ok_q <= 1'b1;
    end
    else if (hold_q < 5'(HOLD_CYCLES))
    begin
      hold_q <= hold_q + 5'h01;
      if (mode_r == BMSL_LOADER &&
          !(boot_enable_select_pin && !loader_or_jump_select_pin))
        sel_ok_q <= 1'b0;
      if (mode_r == BMSL_JUMP &&
          !(boot_enable_select_pin && loader_or_jump_select_pin))
        sel_ok_q <= 1'b0;
    end
  end

  // loader byte counting
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_q <= '0;
      rcvd_q  <= '0;
    end
    else if (we)
    begin
      if (rcvd_q == 8'h00)
        count_q <= rx_b;
      rcvd_q <= rcvd_q + 8'h01;
    end
  end

  // execution start
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      run_q            <= 1'b0;
      exec_addr_q      <= '0;
      loader_waiting_q <= 1'b0;
      ports_to_user_q  <= 1'b0;
    end
    else if (!run_q && !rst_d1_q && hold_q == 5'(HOLD_CYCLES))
    begin
      case (mode_r)
        BMSL_SINGLE:
        begin
          run_q           <= 1'b1;
          ports_to_user_q <= 1'b1;
        end
        BMSL_JUMP:
        begin
          if (sel_ok_q && first_parallel_port_pins == JUMP_KEY)
          begin
            run_q       <= 1'b1;
            exec_addr_q <= {second_parallel_port_pins, third_parallel_port_pins};
          end
        end
        BMSL_LOADER:
        begin
          loader_waiting_q <= 1'b1;
          if (sel_ok_q && rcvd_q != 8'h00 && rcvd_q == count_q)
          begin
            run_q            <= 1'b1;
            exec_addr_q      <= RAM_EXEC;
            loader_waiting_q <= 1'b0;
          end
          // otherwise keep waiting for more bytes
        end
        default:
          run_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      nv_erased_value_q <= ERASED_BYTE;
    else
      nv_erased_value_q <= ERASED_BYTE;
  end
endmodule : bmsl_boot

// file: verilog/bmsl_ram.sv
module bmsl_ram
  import bmsl_pkg::*;
#(
  parameter int unsigned DEPTH = bmsl_pkg::RAM_DEPTH
)
(
  input  wire logic       ref_clk,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic [7:0]      rdata
);
  logic [7:0] mem [DEPTH];

  // no reset on purpose: contents survive reset
  always_ff @(posedge ref_clk)
  begin
    if (we && waddr < 8'(DEPTH))
      mem[waddr] <= wdata;
    rdata <= (raddr < 8'(DEPTH)) ? mem[raddr] : 8'h00;
  end
endmodule : bmsl_ram

// file: verilog/bmsl_uart_rx.sv
module bmsl_uart_rx
  import bmsl_pkg::*;
#(
  parameter int unsigned BIT_CYC = bmsl_pkg::BIT_CYCLES
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       rxd,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [15:0] cnt_q;
  logic [3:0]  bit_q;
  logic        busy_q;
  logic [7:0]  sh_q;

  // 8N1, sample mid-bit
  always_ff @(posedge ref_clk)
  begin
    byte_valid <= 1'b0;
    if (reset)
    begin
      cnt_q      <= '0;
      bit_q      <= '0;
      busy_q     <= 1'b0;
      sh_q       <= '0;
      byte_data  <= '0;
    end
    else if (!busy_q)
    begin
      if (!rxd)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 16'(BIT_CYC / 2);
        bit_q  <= '0;
      end
    end
    else if (cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
    else
    begin
      cnt_q <= 16'(BIT_CYC - 1);
      bit_q <= bit_q + 4'h1;
      if (bit_q == 4'h0 && rxd)
        busy_q <= 1'b0;
      else if (bit_q >= 4'h1 && bit_q <= 4'h8)
        sh_q <= {rxd, sh_q[7:1]};
      else if (bit_q == 4'h9)
      begin
        busy_q <= 1'b0;
        if (rxd)
        begin
          byte_valid <= 1'b1;
          byte_data  <= sh_q;
        end
      end
    end
  end
endmodule : bmsl_uart_rx
